// File: rtl/msec_event_counter.sv
`timescale 1ns/10ps
// Overview of operation
// - Select 03H/20H counts loads blocked by the level-1 data cache for any listed trigger.
// - The load-block count is never below the number of blocked loads up to its all-ones saturation value; extra counts allowed.
// - Select 04H/01H adds one in every cycle that the store buffer drains.
// - Select 04H/02H adds one per cycle while a store waits for global observation.
// - An ordering wait needing a bus read ends when that read's snoop response arrives.
// - Select 04H/08H counts cycles the store port snoops the cache while a store stalls.
// - A store stalled by a snoop is normally resubmitted one cycle later.
// - Select 05H counts memory references crossing an 8-byte boundary.
// - Select 06H counts each load of a new value into a segment register.
// - The segment-load count may include speculative loads on mispredicted paths.
// - Select 07H/00H counts executions of the non-temporal prefetch instruction.
module msec_event_counter #(
    parameter int INCR_WIDTH = 3
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [7:0] event_code_in,
    input wire logic [7:0] unit_mask_in,
    input wire logic [INCR_WIDTH-1:0] l1_miss_limit_blocks_in,
    input wire logic [INCR_WIDTH-1:0] line_split_blocks_in,
    input wire logic [INCR_WIDTH-1:0] partial_read_blocks_in,
    input wire logic [INCR_WIDTH-1:0] locked_load_blocks_in,
    input wire logic store_drain_in,
    input wire logic order_wait_in,
    input wire logic order_bus_read_in,
    input wire logic snoop_response_in,
    input wire logic snoop_port_busy_in,
    input wire logic store_pending_in,
    input wire logic [INCR_WIDTH-1:0] boundary_access_in,
    input wire logic [INCR_WIDTH-1:0] seg_load_in,
    input wire logic [INCR_WIDTH-1:0] nontemporal_prefetch_in,
    output logic [INCR_WIDTH-1:0] incr_out,
    output logic store_retry_out
);

    ////////////////////////////////////////////////////////////////////////////////
    logic order_bus_wait;
    logic next_order_bus_wait;
    logic order_active;
    logic snoop_stall;
    logic [INCR_WIDTH+1:0] l1_sum;
    logic [INCR_WIDTH-1:0] l1_load_block_event;
    logic [INCR_WIDTH-1:0] next_incr;

    // A waiting store that went to the bus stays blocked until its snoop response.
    // A new bus read in the response cycle opens a fresh wait, so setting takes priority.
    always_comb
    begin
        next_order_bus_wait = order_bus_wait;
        if (order_wait_in && order_bus_read_in)
        begin
            next_order_bus_wait = 1'b1;
        end
        else if (snoop_response_in)
        begin
            next_order_bus_wait = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            order_bus_wait <= 1'b0;
        end
        else
        begin
            order_bus_wait <= next_order_bus_wait;
        end
    end

    // The response ends the wait in its own cycle, so that cycle is not counted.
    assign order_active = (order_wait_in || order_bus_wait) && !snoop_response_in;
    assign snoop_stall = snoop_port_busy_in && store_pending_in;

    // Each trigger adds its own count; a load hit by two triggers counts twice, which is allowed.
    assign l1_sum = {2'b00, l1_miss_limit_blocks_in} + {2'b00, line_split_blocks_in}
        + {2'b00, partial_read_blocks_in} + {2'b00, locked_load_blocks_in};
    // Saturation keeps the count from wrapping below the true number of blocked loads.
    assign l1_load_block_event = (l1_sum[INCR_WIDTH+1:INCR_WIDTH] != 2'b00)
        ? {INCR_WIDTH{1'b1}} : l1_sum[INCR_WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_incr = '0;
        unique case (event_code_in)
            msec_pkg::EVT_LOAD_BLOCK:
            begin
                if (unit_mask_in == msec_pkg::UMASK_L1_BLOCK)
                begin
                    next_incr = l1_load_block_event;
                end
            end
            msec_pkg::EVT_STORE_BLOCK:
            begin
                if (unit_mask_in == msec_pkg::UMASK_DRAIN)
                begin
                    next_incr = INCR_WIDTH'(store_drain_in);
                end
                else if (unit_mask_in == msec_pkg::UMASK_ORDER)
                begin
                    next_incr = INCR_WIDTH'(order_active);
                end
                else if (unit_mask_in == msec_pkg::UMASK_SNOOP)
                begin
                    next_incr = INCR_WIDTH'(snoop_stall);
                end
            end
            msec_pkg::EVT_BOUNDARY:
            begin
                if (unit_mask_in == msec_pkg::UMASK_NONE)
                begin
                    next_incr = boundary_access_in;
                end
            end
            msec_pkg::EVT_SEG_LOAD:
            begin
                if (unit_mask_in == msec_pkg::UMASK_NONE)
                begin
                    // Speculative loads are counted as they arrive; no retirement filter.
                    next_incr = seg_load_in;
                end
            end
            msec_pkg::EVT_PREFETCH:
            begin
                if (unit_mask_in == msec_pkg::UMASK_NONE)
                begin
                    next_incr = nontemporal_prefetch_in;
                end
            end
            default:
            begin
                next_incr = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            incr_out <= INCR_WIDTH'(msec_pkg::INCR_RESET);
        end
        else
        begin
            incr_out <= next_incr;
        end
    end

    // The retry strobe follows a snoop stall by one cycle.
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            store_retry_out <= 1'b0;
        end
        else
        begin
            store_retry_out <= snoop_stall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    // Raw codes are used here so that a wrong package constant cannot hide itself.
    AST_L1_BLOCK: assert property (
        (event_code_in == 8'h03 && unit_mask_in == 8'h20
        && (l1_miss_limit_blocks_in != '0 || locked_load_blocks_in != '0))
        |=> incr_out != '0)
        else $error("l1 block not counted");
    AST_L1_NOT_BELOW: assert property (
        (event_code_in == 8'h03 && unit_mask_in == 8'h20)
        |=> incr_out >= $past(line_split_blocks_in)
        && incr_out >= $past(partial_read_blocks_in))
        else $error("l1 count too small");
    AST_DRAIN: assert property (
        (event_code_in == 8'h04 && unit_mask_in == 8'h01)
        |=> incr_out == INCR_WIDTH'($past(store_drain_in)))
        else $error("drain count wrong");
    AST_ORDER: assert property (
        (event_code_in == 8'h04 && unit_mask_in == 8'h02
        && order_wait_in && !snoop_response_in)
        |=> incr_out == 1)
        else $error("order miss");
    AST_ORDER_HOLD: assert property (
        (event_code_in == 8'h04 && unit_mask_in == 8'h02
        && order_bus_wait && !snoop_response_in)
        |=> incr_out == 1)
        else $error("latched order wait not counted");
    AST_ORDER_END: assert property (
        (event_code_in == 8'h04 && unit_mask_in == 8'h02 && snoop_response_in)
        |=> incr_out == 0)
        else $error("order wait not ended");
    AST_SNOOP: assert property (
        (event_code_in == 8'h04 && unit_mask_in == 8'h08)
        |=> incr_out == INCR_WIDTH'($past(snoop_port_busy_in && store_pending_in)))
        else $error("snoop count wrong");
    AST_RETRY: assert property (
        (snoop_port_busy_in && store_pending_in)
        |=> store_retry_out)
        else $error("no retry after snoop stall");
    AST_BOUNDARY: assert property (
        (event_code_in == 8'h05 && unit_mask_in == 8'h00)
        |=> incr_out == $past(boundary_access_in))
        else $error("boundary count wrong");
    AST_SEG: assert property (
        (event_code_in == 8'h06 && unit_mask_in == 8'h00)
        |=> incr_out == $past(seg_load_in))
        else $error("segment count wrong");
    AST_PREFETCH: assert property (
        (event_code_in == 8'h07 && unit_mask_in == 8'h00)
        |=> incr_out == $past(nontemporal_prefetch_in))
        else $error("prefetch count wrong");
    AST_NO_MATCH: assert property (
        (event_code_in == 8'h07 && unit_mask_in != 8'h00)
        |=> incr_out == '0)
        else $error("count without exact match");
    AST_NO_MATCH_MASK: assert property (
        (event_code_in == 8'h04 && !(unit_mask_in inside {8'h01, 8'h02, 8'h08}))
        |=> incr_out == '0)
        else $error("count with unlisted store mask");
    AST_NO_MATCH_CODE: assert property (
        (event_code_in == 8'h08 || event_code_in == 8'h00)
        |=> incr_out == '0)
        else $error("count with unlisted code");

    COV_DRAIN: cover property (event_code_in == 8'h04 && unit_mask_in == 8'h01 && store_drain_in);
    COV_SEG: cover property (event_code_in == 8'h06 && unit_mask_in == 8'h00 && seg_load_in != '0);
    COV_ORDER_BUS: cover property (order_bus_wait ##1 snoop_response_in);
    COV_RETRY: cover property (snoop_stall ##1 store_retry_out);
    COV_L1_SAT: cover property (l1_sum[INCR_WIDTH+1:INCR_WIDTH] != 2'b00);

endmodule : msec_event_counter

// File: rtl/msec_pkg.sv
package msec_pkg;

    // Event selection codes.
    localparam logic [7:0] EVT_LOAD_BLOCK = 8'h03;
    localparam logic [7:0] EVT_STORE_BLOCK = 8'h04;
    localparam logic [7:0] EVT_BOUNDARY = 8'h05;
    localparam logic [7:0] EVT_SEG_LOAD = 8'h06;
    localparam logic [7:0] EVT_PREFETCH = 8'h07;

    // Unit masks.
    localparam logic [7:0] UMASK_L1_BLOCK = 8'h20;
    localparam logic [7:0] UMASK_DRAIN = 8'h01;
    localparam logic [7:0] UMASK_ORDER = 8'h02;
    localparam logic [7:0] UMASK_SNOOP = 8'h08;
    localparam logic [7:0] UMASK_NONE = 8'h00;

    // Boundary that a misaligned reference crosses, in bytes.
    localparam int BOUNDARY_BYTES = 8;

    // Cycles from a snoop stall to the store's resubmission.
    localparam int SNOOP_RETRY_CYCLES = 1;

    // Reset value of the increment output.
    localparam logic [2:0] INCR_RESET = 3'h0;

endpackage : msec_pkg

// File: tb/msec_pipe_model.sv
`timescale 1ns/10ps
// Load/store pipeline stand-in; counts hold miss, split, partial, lock, boundary, segment, prefetch.
module msec_pipe_model (
    input wire logic mclk_in,
    input wire logic [31:0] rnd_in,
    output logic [6:0][2:0] counts_out,
    output logic [5:0] flags_out
);
    logic bus_pend = 1'b0;
    logic w;
    logic r;
    initial
    begin
        counts_out = '0;
        flags_out = '0;
    end
    always @(negedge mclk_in)
    begin
        w = rnd_in[22] & rnd_in[23];
        // A snoop response only answers a bus read that is still outstanding.
        r = bus_pend & rnd_in[25];
        bus_pend <= (w & rnd_in[24]) | (bus_pend & ~r);
        counts_out <= rnd_in[20:0];
        flags_out <= {rnd_in[28], rnd_in[27], r, rnd_in[24], w, rnd_in[21]};
    end
endmodule : msec_pipe_model

// File: tb/msec_event_counter_test.sv
`timescale 1ns/10ps
module msec_event_counter_test;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] event_code_in = 8'h00;
    logic [7:0] unit_mask_in = 8'h00;
    logic [31:0] rnd = 32'h0000_0000;
    logic [6:0][2:0] counts;
    logic [5:0] flags;
    logic [2:0] incr_out;
    logic store_retry_out;
    int errors = 0;
    int checks = 0;
    int lat = 0;
    int armed = 0;
    logic seeded = 1'b0;
    logic [15:0] sel_tab [13] = '{16'h0320, 16'h0401, 16'h0402, 16'h0408, 16'h0500, 16'h0600,
        16'h0700, 16'h0310, 16'h0404, 16'h0501, 16'h0720, 16'h0000, 16'h0820};
    msec_pipe_model pipe (.mclk_in(mclk_in), .rnd_in(rnd), .counts_out(counts), .flags_out(flags));
    msec_event_counter #(.INCR_WIDTH(3)) uut (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .event_code_in(event_code_in),
        .unit_mask_in(unit_mask_in), .l1_miss_limit_blocks_in(counts[0]),
        .line_split_blocks_in(counts[1]), .partial_read_blocks_in(counts[2]),
        .locked_load_blocks_in(counts[3]), .store_drain_in(flags[0]), .order_wait_in(flags[1]),
        .order_bus_read_in(flags[2]), .snoop_response_in(flags[3]),
        .snoop_port_busy_in(flags[4]), .store_pending_in(flags[5]),
        .boundary_access_in(counts[4]), .seg_load_in(counts[5]),
        .nontemporal_prefetch_in(counts[6]), .incr_out(incr_out), .store_retry_out(store_retry_out)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_incr(input logic [2:0] exp_v);
        checks++;
        if (incr_out !== exp_v)
        begin
            errors++;
            $display("mismatch incr_out expected %0d seen %0d", exp_v, incr_out);
        end
    endtask : cmp_incr
    task automatic cmp_retry(input logic exp_v);
        checks++;
        if (store_retry_out !== exp_v)
        begin
            errors++;
            $display("mismatch store_retry_out expected %0d seen %0d", exp_v, store_retry_out);
        end
    endtask : cmp_retry
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    // Inputs now on the pins were sampled at the last rising edge, so outputs answer them.
    task automatic step_model();
        int sum;
        int ord;
        int exp_i;
        sum = counts[0] + counts[1] + counts[2] + counts[3];
        ord = (flags[1] || lat != 0) && !flags[3];
        lat = (flags[1] && flags[2]) ? 1 : (flags[3] ? 0 : lat);
        case ({event_code_in, unit_mask_in})
            16'h0320: exp_i = (sum > 7) ? 7 : sum;
            16'h0401: exp_i = flags[0];
            16'h0402: exp_i = ord;
            16'h0408: exp_i = flags[4] && flags[5];
            16'h0500: exp_i = counts[4];
            16'h0600: exp_i = counts[5];
            16'h0700: exp_i = counts[6];
            default: exp_i = 0;
        endcase
        if (armed != 0)
        begin
            cmp_incr(3'(exp_i));
            cmp_retry(flags[4] && flags[5]);
        end
    endtask : step_model
    initial
    begin
        forever #2.5 mclk_in = ~mclk_in;
    end
    always @(negedge mclk_in)
    begin
        // The seed goes to this process because it is the one that draws the values.
        if (!seeded)
            void'($urandom(32'hbc7d_86f7));
        seeded = 1'b1;
        rnd <= $urandom;
        if (resetn_in)
            step_model();
        else
            lat = 0;
        armed = resetn_in;
    end
    initial
    begin
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        resetn_in <= 1'b1;
        foreach (sel_tab[i])
        begin
            @(negedge mclk_in);
            event_code_in <= sel_tab[i][15:8];
            unit_mask_in <= sel_tab[i][7:0];
            repeat (200) @(negedge mclk_in);
            $display("test select %h done", sel_tab[i]);
        end
        // A second reset in mid-run must also clear any latched ordering wait.
        event_code_in <= 8'h04;
        unit_mask_in <= 8'h02;
        resetn_in <= 1'b0;
        repeat (3) @(negedge mclk_in);
        resetn_in <= 1'b1;
        repeat (200) @(negedge mclk_in);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule : msec_event_counter_test
